/* mdsc_regs.vh */
// Register offsets, field positions, writable masks, reset value and frame counts
`ifndef MDSC_REGS_VH
`define MDSC_REGS_VH
`define MDSC_ADDR_HB_OUT     5'h01
`define MDSC_ADDR_HB_CTL     5'h02
`define MDSC_ADDR_SYS_CTL    5'h03
`define MDSC_ADDR_IRQ_EN     5'h04
`define MDSC_ADDR_IRQ_FLAGS  5'h05
`define MDSC_ADDR_RST_EN     5'h06
`define MDSC_ADDR_ANA_SEL    5'h07
`define MDSC_ADDR_RSVD_A     5'h08
`define MDSC_ADDR_RSVD_B     5'h09
`define MDSC_ADDR_WDG_CTL    5'h0A
`define MDSC_ADDR_PWR_OUT    5'h0B
`define MDSC_ADDR_SYS_STAT   5'h0C
// Interrupt flag / enable bit positions
`define MDSC_BIT_BUS_EDGE    5
`define MDSC_BIT_TEMP_HIGH   4
`define MDSC_BIT_SUP_LOW     3
`define MDSC_BIT_SUP_HIGH    2
`define MDSC_BIT_OVERCUR     1
// Reset enable bit positions
`define MDSC_BIT_TEMP_TEST   7
`define MDSC_BIT_SUP_RST_EN  1
`define MDSC_BIT_TEMP_RST_EN 0
// System status bit positions
`define MDSC_STAT_BUS_CL     6
`define MDSC_STAT_HVDD_OC    5
`define MDSC_STAT_SUP_LOW    3
`define MDSC_STAT_SUP_HIGH   2
`define MDSC_STAT_HB_OC      1
`define MDSC_STAT_TEMP_HIGH  0
// Writable masks
`define MDSC_MASK_HB_CTL     8'hC7
`define MDSC_MASK_SYS_CTL    8'hE0
`define MDSC_MASK_IRQ        8'h3E
`define MDSC_MASK_RST_EN     8'h83
`define MDSC_MASK_ANA_SEL    8'h0F
`define MDSC_MASK_WDG_CTL    8'h10
`define MDSC_MASK_PWR_OUT    8'h02
`define MDSC_RESET_VAL       8'h00
// Transfer framing
`define MDSC_FRAME_BITS      5'd16
`define MDSC_PARITY_BIT_IDX  5'd6
`endif

/* mdsc_spi_ctrl.v */
// SPI slave register file with flag, interrupt and reset-source logic
`timescale 1ns/10ps
`include "mdsc_regs.vh"
module mdsc_spi_ctrl (
  input  wire       clk,
  input  wire       reset,
  input  wire       spi_cs_n,
  input  wire       serial_clock,
  input  wire       spi_mosi,
  output reg        spi_miso_o,
  output wire       spi_miso_oe,
  input  wire       analog_reset_in_n,
  output wire       analog_reset_out_o,
  output wire       analog_reset_out_oe,
  output wire       analog_irq_out_o,
  output wire       analog_irq_out_oe,
  input  wire       bus_edge_event,
  input  wire       temp_high_cond,
  input  wire       temp_over_limit,
  input  wire       supply_low_cond,
  input  wire       supply_high_cond,
  input  wire       hb_overcurrent,
  input  wire       hvdd_overcurrent,
  input  wire       bus_current_limit,
  input  wire       vdd_low,
  input  wire       watchdog_timeout,
  output wire       temp_test_threshold,
  output wire [7:0] half_bridge_output,
  output wire [7:0] half_bridge_control,
  output wire [7:0] system_control,
  output wire [7:0] analog_select,
  output wire [7:0] watchdog_control,
  output wire [7:0] power_output
);
  // Two-flop synchronisers for every asynchronous input
  localparam NSYNC = 14;
  wire [NSYNC-1:0] async_in = {spi_cs_n, serial_clock, spi_mosi, analog_reset_in_n, bus_edge_event,
                               temp_high_cond, temp_over_limit, supply_low_cond, supply_high_cond,
                               hb_overcurrent, hvdd_overcurrent, bus_current_limit, vdd_low,
                               watchdog_timeout};
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  always @(posedge clk)
  begin
    if (reset)
    begin
      // Idle levels: select, reset pin and bus line high, all else low
      sync1_q <= 14'h2600;
      sync2_q <= 14'h2600;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end
  wire cs_n_s    = sync2_q[13];
  wire sck_s     = sync2_q[12];
  wire mosi_s    = sync2_q[11];
  wire ext_rst_n = sync2_q[10];
  wire edge_s    = sync2_q[9];
  wire thigh_s   = sync2_q[8];
  wire tover_s   = sync2_q[7];
  wire slow_s    = sync2_q[6];
  wire shigh_s   = sync2_q[5];
  wire hboc_s    = sync2_q[4];
  wire hvoc_s    = sync2_q[3];
  wire buscl_s   = sync2_q[2];
  wire vddlow_s  = sync2_q[1];
  wire wdg_s     = sync2_q[0];

  // Internal reset sources combined
  reg  [7:0] rst_en_q;
  wire temp_rst   = tover_s & rst_en_q[`MDSC_BIT_TEMP_RST_EN];
  wire supply_rst = shigh_s & rst_en_q[`MDSC_BIT_SUP_RST_EN];
  wire pin_rst    = supply_rst | vddlow_s;
  wire int_rst    = reset | ~ext_rst_n | wdg_s | temp_rst | pin_rst;
  // Open-drain reset pin: drive low while asserted
  assign analog_reset_out_o  = 1'b0;
  assign analog_reset_out_oe = pin_rst | temp_rst | wdg_s;

  // Serial clock, chip select and bus line edges
  reg  sck_prev_q;
  reg  cs_prev_q;
  reg  edge_prev_q;
  always @(posedge clk)
  begin
    if (reset)
    begin
      sck_prev_q  <= 1'b0;
      cs_prev_q   <= 1'b1;
      edge_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q  <= sck_s;
      cs_prev_q   <= cs_n_s;
      edge_prev_q <= edge_s;
    end
  end
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire cs_fall  = ~cs_n_s & cs_prev_q;
  wire cs_rise  = cs_n_s & ~cs_prev_q;
  wire bus_fall = ~edge_s & edge_prev_q;

  // Register storage
  reg  [7:0] hb_out_q;
  reg  [7:0] hb_ctl_q;
  reg  [7:0] sys_ctl_q;
  reg  [7:0] irq_en_q;
  reg  [7:0] ana_sel_q;
  reg  [7:0] wdg_ctl_q;
  reg  [7:0] pwr_out_q;
  reg        f_edge_q;
  reg        f_thigh_q;
  reg        f_slow_q;
  reg        f_shigh_q;
  reg        hb_oc_q;
  reg        hvdd_oc_q;
  wire       f_oc = hb_oc_q | hvdd_oc_q;
  wire [7:0] irq_flags = {2'b00, f_edge_q, f_thigh_q, f_slow_q, f_shigh_q, f_oc, 1'b0};
  wire [7:0] sys_stat  = {1'b0, buscl_s, hvdd_oc_q, 1'b0, f_slow_q, f_shigh_q, hb_oc_q, f_thigh_q};

  // Register read mux
  function [7:0] rd_mux;
    input [4:0] a;
    begin
      case (a)
        `MDSC_ADDR_HB_OUT:    rd_mux = hb_out_q;
        `MDSC_ADDR_HB_CTL:    rd_mux = hb_ctl_q;
        `MDSC_ADDR_SYS_CTL:   rd_mux = sys_ctl_q;
        `MDSC_ADDR_IRQ_EN:    rd_mux = irq_en_q;
        `MDSC_ADDR_IRQ_FLAGS: rd_mux = irq_flags;
        `MDSC_ADDR_RST_EN:    rd_mux = rst_en_q;
        `MDSC_ADDR_ANA_SEL:   rd_mux = ana_sel_q;
        `MDSC_ADDR_WDG_CTL:   rd_mux = wdg_ctl_q;
        `MDSC_ADDR_PWR_OUT:   rd_mux = pwr_out_q;
        `MDSC_ADDR_SYS_STAT:  rd_mux = sys_stat;
        default:              rd_mux = 8'h00;
      endcase
    end
  endfunction

  // Shift engine
  reg  [4:0]  cnt_q;
  reg  [15:0] rx_q;
  reg  [15:0] tx_q;
  reg         active_q;
  always @(posedge clk)
  begin
    if (int_rst)
    begin
      cnt_q      <= 5'd0;
      rx_q       <= 16'h0000;
      tx_q       <= 16'h0000;
      active_q   <= 1'b0;
      spi_miso_o <= 1'b0;
    end
    else if (cs_fall)
    begin
      cnt_q    <= 5'd0;
      active_q <= 1'b1;
      tx_q     <= {sys_stat, 8'h00};
    end
    else if (active_q & ~cs_n_s)
    begin
      if (sck_rise)
      begin
        spi_miso_o <= tx_q[15];
        tx_q       <= {tx_q[14:0], 1'b0};
      end
      if (sck_fall)
      begin
        rx_q <= {rx_q[14:0], mosi_s};
        if (cnt_q != 5'd31)
          cnt_q <= cnt_q + 5'd1;
        if (cnt_q == `MDSC_PARITY_BIT_IDX)
          tx_q[14:7] <= rd_mux(rx_q[4:0]);
      end
    end
    else if (cs_n_s)
      active_q <= 1'b0;
  end
  assign spi_miso_oe = active_q & ~cs_n_s;

  // Frame decode at chip select rise
  wire [4:0] w_addr   = rx_q[14:10];
  wire       w_read   = rx_q[15];
  wire       par_ok   = (^rx_q[15:10]) == rx_q[9];
  wire       frame_ok = active_q & cs_rise & (cnt_q == `MDSC_FRAME_BITS);
  wire       wr_en    = frame_ok & ~w_read & par_ok;
  wire [7:0] wd       = rx_q[7:0];
  wire       wr_flags = wr_en & (w_addr == `MDSC_ADDR_IRQ_FLAGS);
  wire       wr_stat  = wr_en & (w_addr == `MDSC_ADDR_SYS_STAT);

  always @(posedge clk)
  begin
    if (int_rst)
    begin
      hb_out_q  <= `MDSC_RESET_VAL;
      hb_ctl_q  <= `MDSC_RESET_VAL;
      sys_ctl_q <= `MDSC_RESET_VAL;
      irq_en_q  <= `MDSC_RESET_VAL;
      rst_en_q  <= `MDSC_RESET_VAL;
      ana_sel_q <= `MDSC_RESET_VAL;
      wdg_ctl_q <= `MDSC_RESET_VAL;
      pwr_out_q <= `MDSC_RESET_VAL;
    end
    else if (wr_en)
    begin
      case (w_addr)
        `MDSC_ADDR_HB_OUT:  hb_out_q  <= wd;
        `MDSC_ADDR_HB_CTL:  hb_ctl_q  <= wd & `MDSC_MASK_HB_CTL;
        `MDSC_ADDR_SYS_CTL: sys_ctl_q <= wd & `MDSC_MASK_SYS_CTL;
        `MDSC_ADDR_IRQ_EN:  irq_en_q  <= wd & `MDSC_MASK_IRQ;
        `MDSC_ADDR_RST_EN:  rst_en_q  <= wd & `MDSC_MASK_RST_EN;
        `MDSC_ADDR_ANA_SEL: ana_sel_q <= wd & `MDSC_MASK_ANA_SEL;
        `MDSC_ADDR_WDG_CTL: wdg_ctl_q <= wd & `MDSC_MASK_WDG_CTL;
        `MDSC_ADDR_PWR_OUT: pwr_out_q <= wd & `MDSC_MASK_PWR_OUT;
        default:            hb_out_q  <= hb_out_q;
      endcase
    end
  end

  // Sticky flags: set wins, clear by 1 only when condition gone
  always @(posedge clk)
  begin
    if (int_rst)
    begin
      f_edge_q  <= 1'b0;
      f_thigh_q <= 1'b0;
      f_slow_q  <= 1'b0;
      f_shigh_q <= 1'b0;
      hb_oc_q   <= 1'b0;
      hvdd_oc_q <= 1'b0;
    end
    else
    begin
      if (bus_fall)
        f_edge_q <= 1'b1;
      else if (wr_flags & wd[`MDSC_BIT_BUS_EDGE])
        f_edge_q <= 1'b0;
      if (thigh_s)
        f_thigh_q <= 1'b1;
      else if (wr_flags & wd[`MDSC_BIT_TEMP_HIGH])
        f_thigh_q <= 1'b0;
      if (slow_s)
        f_slow_q <= 1'b1;
      else if (wr_flags & wd[`MDSC_BIT_SUP_LOW])
        f_slow_q <= 1'b0;
      if (shigh_s)
        f_shigh_q <= 1'b1;
      else if (wr_flags & wd[`MDSC_BIT_SUP_HIGH])
        f_shigh_q <= 1'b0;
      if (hboc_s)
        hb_oc_q <= 1'b1;
      else if (wr_stat & wd[`MDSC_STAT_HB_OC])
        hb_oc_q <= 1'b0;
      if (hvoc_s)
        hvdd_oc_q <= 1'b1;
      else if (wr_stat & wd[`MDSC_STAT_HVDD_OC])
        hvdd_oc_q <= 1'b0;
    end
  end

  // Interrupt request, open-drain active low
  wire irq_req = |(irq_flags & irq_en_q & `MDSC_MASK_IRQ);
  assign analog_irq_out_o  = 1'b0;
  assign analog_irq_out_oe = irq_req;

  assign temp_test_threshold = rst_en_q[`MDSC_BIT_TEMP_TEST];
  assign half_bridge_output  = hb_out_q;
  assign half_bridge_control = hb_ctl_q;
  assign system_control      = sys_ctl_q;
  assign analog_select       = ana_sel_q;
  assign watchdog_control    = wdg_ctl_q;
  assign power_output        = pwr_out_q;
endmodule

/* mdsc_checker_properties.sv */
// Concurrent checks on the ports of the SPI control block
`timescale 1ns/10ps
module mdsc_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       spi_cs_n,
  input wire logic       serial_clock,
  input wire logic       spi_miso_o,
  input wire logic       spi_miso_oe,
  input wire logic       analog_reset_in_n,
  input wire logic       analog_reset_out_o,
  input wire logic       analog_reset_out_oe,
  input wire logic       analog_irq_out_o,
  input wire logic       analog_irq_out_oe,
  input wire logic       vdd_low,
  input wire logic       watchdog_timeout,
  input wire logic       temp_test_threshold,
  input wire logic [7:0] half_bridge_output
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_miso_idle_hiz: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_miso_sel_drive: assert property ((!spi_cs_n && analog_reset_in_n && !analog_reset_out_oe) [*6] |-> spi_miso_oe)
    else $error("miso not driven while selected");
  a_miso_rise_only: assert property (spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso_o)
    |-> $past(serial_clock, 2) || $past(serial_clock, 3) || $past(serial_clock, 4))
    else $error("miso changed away from a rising clock");
  a_irq_open_drain: assert property (analog_irq_out_oe |-> !analog_irq_out_o)
    else $error("irq pin driven high");
  a_vdd_low_reset: assert property (vdd_low [*4] |-> analog_reset_out_oe && !analog_reset_out_o)
    else $error("low supply did not pull reset");
  a_wdg_reset_out: assert property (watchdog_timeout [*4] |-> analog_reset_out_oe)
    else $error("watchdog timeout did not pull reset");
  a_ext_reset_clear: assert property ($rose(analog_reset_in_n)
    |-> !analog_irq_out_oe && !temp_test_threshold && half_bridge_output == 8'h00)
    else $error("state survived external reset");
  a_rst_en_cleared: assert property ($fell(reset) ##0 (!vdd_low && !watchdog_timeout) [*4]
    |-> !analog_reset_out_oe)
    else $error("reset output active after reset");
  a_write_on_cs_rise: assert property ($changed(half_bridge_output) && half_bridge_output != 8'h00
    |-> spi_cs_n && (!$past(spi_cs_n, 3) || !$past(spi_cs_n, 4) || !$past(spi_cs_n, 5)))
    else $error("register changed away from frame end");
  cover property ($fell(spi_cs_n));
  cover property ($rose(analog_irq_out_oe));
  cover property ($rose(analog_reset_out_oe));
endmodule
bind mdsc_spi_ctrl mdsc_checker u_chk (.clk, .reset, .spi_cs_n, .serial_clock, .spi_miso_o, .spi_miso_oe,
  .analog_reset_in_n, .analog_reset_out_o, .analog_reset_out_oe, .analog_irq_out_o, .analog_irq_out_oe,
  .vdd_low, .watchdog_timeout, .temp_test_threshold, .half_bridge_output);

/* mdsc_spi_master.sv */
// Microcontroller model acting as SPI master
`timescale 1ns/10ps
module mdsc_spi_master (
  input wire logic clk,
  input wire logic spi_miso,
  output logic     spi_cs_n,
  output logic     serial_clock,
  output logic     spi_mosi
);
  initial
  begin
    spi_cs_n = 1'b1;
    serial_clock = 1'b0;
    spi_mosi = 1'b0;
  end
  // One frame of n clocks, MSB first, clock idle low
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk);
    #0.3;
    spi_cs_n = 1'b0;
    for (int b = 15; b > 15 - n; b--)
    begin
      #32;
      serial_clock = 1'b1;
      spi_mosi = tx[b];
      #32;
      serial_clock = 1'b0;
      rx[b] = spi_miso;
    end
    #32;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the SPI control block
`timescale 1ns/10ps
`include "mdsc_regs.vh"
module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  src = 5'h00;
  logic [5:0]  cond = 6'h00;
  logic [7:0]  seed = 8'h13;
  logic [15:0] rx;
  logic        miso_last = 1'b0;
  logic        rst_seen = 1'b0;
  int          fail_count = 0;
  int          checked = 0;
  int          i;
  logic [4:0]  adr [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h0A, 5'h0B};
  logic [7:0]  msk [8] = '{8'hFF, `MDSC_MASK_HB_CTL, `MDSC_MASK_SYS_CTL, `MDSC_MASK_IRQ, `MDSC_MASK_RST_EN,
                          `MDSC_MASK_ANA_SEL, `MDSC_MASK_WDG_CTL, `MDSC_MASK_PWR_OUT};
  logic [7:0]  shadow [8] = '{default: 8'h00};
  wire         spi_cs_n, serial_clock, spi_mosi, spi_miso_o, spi_miso_oe, temp_test_threshold;
  wire         analog_reset_out_o, analog_reset_out_oe, analog_irq_out_o, analog_irq_out_oe;
  wire         miso_pin = spi_miso_oe ? spi_miso_o : ~miso_last;
  wire         irq_pin = analog_irq_out_oe ? analog_irq_out_o : 1'b1;
  wire         analog_reset_in_n = ~src[4];
  wire         temp_over_limit = src[0];
  wire         supply_high_cond = cond[2] | src[1];
  wire         vdd_low = src[2];
  wire         watchdog_timeout = src[3];
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (spi_miso_oe)
      miso_last <= spi_miso_o;
    if (analog_reset_out_oe)
      rst_seen = 1'b1;
  end
  mdsc_spi_master u_mst (.clk, .spi_miso(miso_pin), .spi_cs_n, .serial_clock, .spi_mosi);
  mdsc_spi_ctrl uut (.clk, .reset, .spi_cs_n, .serial_clock, .spi_mosi, .spi_miso_o, .spi_miso_oe,
    .analog_reset_in_n, .analog_reset_out_o, .analog_reset_out_oe, .analog_irq_out_o, .analog_irq_out_oe,
    .bus_edge_event(~cond[5]), .temp_high_cond(cond[4]), .temp_over_limit, .supply_low_cond(cond[3]),
    .supply_high_cond, .hb_overcurrent(cond[1]), .hvdd_overcurrent(cond[0]), .bus_current_limit(1'b0),
    .vdd_low, .watchdog_timeout, .temp_test_threshold, .half_bridge_output(), .half_bridge_control(),
    .system_control(), .analog_select(), .watchdog_control(), .power_output());
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic bad);
    u_mst.xfer({1'b0, a, ^a ^ bad, 1'b0, d}, 16, rx);
  endtask
  // Reads carry a random data byte and random parity
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    seed = nxt(seed);
    u_mst.xfer({1'b1, a, ~^a ^ seed[0], 1'b0, seed}, 16, rx);
    check("read data", rx[7:0], exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    finish_test;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 32; a++)
    begin
      rd(a[4:0], 8'h00);
      check("status", rx[15:8], 8'h00);
    end
    for (int k = 0; k < 24; k++)
    begin
      i = k % 8;
      seed = nxt(seed);
      wr(adr[i], seed, 1'b0);
      check("old data", rx[7:0], shadow[i]);
      shadow[i] = seed & msk[i];
      rd(adr[i], shadow[i]);
      check("test bit", {7'h00, temp_test_threshold}, {7'h00, shadow[4][7]});
    end
    wr(5'h01, ~shadow[0], 1'b1);
    rd(5'h01, shadow[0]);
    u_mst.xfer({8'h06, ~shadow[0]}, 15, rx);
    rd(5'h01, shadow[0]);
    wr(5'h08, 8'hFF, 1'b0);
    rd(5'h08, 8'h00);
    wr(5'h06, 8'h00, 1'b0);
    wr(5'h04, 8'h00, 1'b0);
    for (int k = 2; k < 5; k++)
    begin
      cond[k] <= 1'b1;
      wr(5'h05, 8'h01 << k, 1'b0);
      rd(5'h05, 8'h01 << k);
      check("irq masked", {7'h00, irq_pin}, 8'h01);
      wr(5'h04, 8'h01 << k, 1'b0);
      check("irq raised", {7'h00, irq_pin}, 8'h00);
      cond[k] <= 1'b0;
      wr(5'h05, 8'h00, 1'b0);
      rd(5'h05, 8'h01 << k);
      wr(5'h05, 8'h01 << k, 1'b0);
      rd(5'h05, 8'h00);
      check("irq cleared", {7'h00, irq_pin}, 8'h01);
    end
    check("masked reset", {7'h00, rst_seen}, 8'h00);
    for (int j = 0; j < 2; j++)
    begin
      cond[j] <= 1'b1;
      repeat (10) @(posedge clk);
      cond[j] <= 1'b0;
      wr(5'h05, 8'h02, 1'b0);
      rd(5'h05, 8'h02);
      wr(5'h0C, j ? 8'h02 : 8'h20, 1'b0);
      rd(5'h05, 8'h00);
    end
    for (int k = 0; k < 7; k++)
    begin
      i = (k < 2) ? k : k - 2;
      wr(5'h01, 8'hA5, 1'b0);
      wr(5'h06, (k > 1 && i < 2) ? 8'h01 << i : 8'h00, 1'b0);
      rst_seen = 1'b0;
      src <= 5'h01 << i;
      repeat (20) @(posedge clk);
      src <= 5'h00;
      repeat (20) @(posedge clk);
      check("reset pin", {7'h00, rst_seen}, {7'h00, k > 1 && i < 4});
      rd(5'h01, (k > 1) ? 8'h00 : 8'hA5);
      rd(5'h06, 8'h00);
    end
    finish_test;
  end
endmodule
